// >>> rtl/cms_map.vh
// constants for the can message storage block: offsets, fields, resets
// assumes a 32-bit axi4-lite slave with 8-bit byte addresses, one byte per word
`ifndef CMS_MAP_VH
`define CMS_MAP_VH

// register byte offsets
`define CMS_OFS_CTRL 8'h00
`define CMS_OFS_TXFLG 8'h04
`define CMS_OFS_ABORT_REQUEST_BIT 8'h08
`define CMS_OFS_ABORT_ACKNOWLEDGE_FLAG 8'h0c
`define CMS_OFS_TXSEL 8'h10
`define CMS_OFS_RXFLG 8'h14
`define CMS_OFS_TXWIN 8'h40
`define CMS_OFS_RXWIN 8'h80
`define CMS_WIN_MASK 8'hc0

// control register fields
`define CMS_CTRL_INIT_BIT 0
`define CMS_CTRL_TIME_BIT 1
`define CMS_CTRL_LOOP_BIT 2
`define CMS_CTRL_RESET 3'h1

// receive flag register fields
`define CMS_RXF_FULL_BIT 0
`define CMS_RXF_OVR_BIT 1

// transmit flag resets: all buffers empty, nothing requested
`define CMS_TXE_RESET 3'h7
`define CMS_TXSEL_RESET 3'h0

// byte layout inside a transmit buffer window
`define CMS_TX_LOCAL_PRIORITY_FIELD_IDX 4'hd
`define CMS_TX_STAMP_HI_IDX 4'he
`define CMS_TX_STAMP_LO_IDX 4'hf
// byte layout inside a receive buffer
`define CMS_RX_STAMP_HI_IDX 4'hd
`define CMS_RX_STAMP_LO_IDX 4'he
`define CMS_MSG_BYTES 4'hd
`define CMS_RX_BYTES 4'hf

// receive fifo
`define CMS_FIFO_DEPTH 3'h5
`define CMS_FIFO_LAST 3'h4

// axi responses
`define CMS_RESP_OKAY 2'h0
`define CMS_RESP_SLVERR 2'h2

`endif

// >>> rtl/cms_top.v
// can message storage: three prioritised transmit buffers, five-stage receive
// fifo, time stamp timer and an axi4-lite register slave.
// assumes a protocol engine on the pe_* ports and cpu software on axi.
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`include "cms_map.vh"

module cms_top (
  input wire clk_in,
  input wire resetn_in,
  input wire ce_in,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  output wire [1:0] s_axi_bresp_out,
  output wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [7:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  output wire [31:0] s_axi_rdata_out,
  output wire [1:0] s_axi_rresp_out,
  output wire s_axi_rvalid_out,
  output wire s_axi_rready_unused_out,
  input wire s_axi_rready_in,
  // protocol engine side
  input wire pe_bit_tick_in,
  input wire pe_arb_in,
  input wire pe_tx_done_in,
  input wire pe_tx_fail_in,
  input wire pe_rx_wr_in,
  input wire [3:0] pe_rx_idx_in,
  input wire [7:0] pe_rx_byte_in,
  input wire pe_rx_ok_in,
  input wire pe_rx_accept_in,
  output wire tx_pick_valid_out,
  output wire [1:0] tx_pick_idx_out,
  output wire [103:0] tx_msg_out,
  output wire ack_enable_out,
  output wire init_mode_out,
  output wire tx_event_out,
  output wire rx_event_out,
  output wire overrun_event_out
);

  // reset synchroniser
  reg rst_meta_reg; // first stage, read only by the second
  reg rst_sync_reg; // design-wide active-low reset
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rst_n = rst_sync_reg;

  // --- functions ---
  // lowest set bit as one-hot, used for buffer select
  function [2:0] lowest_bit;
    input [2:0] v;
    begin
      if (v[0]) lowest_bit = 3'h1;
      else if (v[1]) lowest_bit = 3'h2;
      else if (v[2]) lowest_bit = 3'h4;
      else lowest_bit = 3'h0;
    end
  endfunction

  // one-hot to index
  function [1:0] hot_index;
    input [2:0] v;
    begin
      if (v[1]) hot_index = 2'h1;
      else if (v[2]) hot_index = 2'h2;
      else hot_index = 2'h0;
    end
  endfunction

  // {found, index}: lowest priority value, strict less keeps lower index
  function [2:0] pick_buffer;
    input [2:0] rdy;
    input [7:0] p0;
    input [7:0] p1;
    input [7:0] p2;
    reg [7:0] best;
    reg [2:0] res;
    begin
      best = 8'hff;
      res = 3'h0;
      if (rdy[0]) begin
        best = p0;
        res = 3'h4;
      end
      if (rdy[1] && (!res[2] || p1 < best)) begin
        best = p1;
        res = 3'h5;
      end
      if (rdy[2] && (!res[2] || p2 < best)) begin
        best = p2;
        res = 3'h6;
      end
      pick_buffer = res;
    end
  endfunction

  // flat index of a transmit buffer byte
  function [5:0] tx_index;
    input [1:0] buf_idx;
    input [3:0] byte_idx;
    begin
      tx_index = {buf_idx, byte_idx};
    end
  endfunction

  // flat index of a receive fifo byte, 15 bytes per stage
  function [6:0] rx_index;
    input [2:0] stage;
    input [3:0] byte_idx;
    begin
      rx_index = ({stage, 4'h0} - {4'h0, stage}) + {3'h0, byte_idx};
    end
  endfunction

  // next fifo pointer, wraps after the fifth stage
  function [2:0] ptr_inc;
    input [2:0] p;
    begin
      ptr_inc = (p == `CMS_FIFO_LAST) ? 3'h0 : p + 3'h1;
    end
  endfunction

  // --- state ---
  reg [2:0] ctrl_reg; // loop, time, init
  reg [2:0] txe_reg; // tx_buffer_empty_flag per buffer
  reg [2:0] abort_request_bit_reg; // abort_request_bit per buffer
  reg [2:0] abort_acknowledge_flag_reg; // abort_acknowledge_flag per buffer
  reg [2:0] sel_reg; // tx_buffer_select, one-hot
  reg ovr_reg; // sticky overrun flag
  reg [7:0] tx_mem_reg [0:47]; // three 16-byte transmit buffers
  reg [7:0] bg_mem_reg [0:12]; // rx_background_buffer message bytes
  reg [7:0] rx_mem_reg [0:74]; // five 15-byte fifo stages
  reg [2:0] rd_ptr_reg; // stage shown as rx_foreground_buffer
  reg [2:0] wr_ptr_reg; // next free stage
  reg [2:0] count_reg; // stored messages
  reg [15:0] timer_reg; // stamping timer
  reg active_reg; // a buffer is on the bus
  reg [1:0] active_idx_reg; // which one
  reg pick_valid_reg;
  reg [103:0] tx_msg_reg;
  reg ack_en_reg;
  reg tx_ev_reg;
  reg rx_ev_reg;
  reg ovr_ev_reg;
  // axi slave state
  reg awready_reg;
  reg wready_reg;
  reg aw_have_reg;
  reg w_have_reg;
  reg [7:0] aw_addr_reg;
  reg [7:0] w_byte_reg;
  reg w_strb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg arready_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;

  wire init_mode = ctrl_reg[`CMS_CTRL_INIT_BIT];
  wire time_en = ctrl_reg[`CMS_CTRL_TIME_BIT];
  wire loop_en = ctrl_reg[`CMS_CTRL_LOOP_BIT];
  wire [1:0] sel_idx = hot_index(sel_reg);
  wire sel_empty = |(sel_reg & txe_reg);

  // --- write decode ---
  wire wr_fire = ce_in & aw_have_reg & w_have_reg & ~bvalid_reg;
  wire wr_en = wr_fire & w_strb_reg;
  wire wr_txflg = wr_en && aw_addr_reg == `CMS_OFS_TXFLG;
  wire wr_abort_request_bit = wr_en && aw_addr_reg == `CMS_OFS_ABORT_REQUEST_BIT;
  wire wr_rxflg = wr_en && aw_addr_reg == `CMS_OFS_RXFLG;
  wire wr_txwin = wr_en && (aw_addr_reg & `CMS_WIN_MASK) == `CMS_OFS_TXWIN;
  wire [3:0] wr_win_idx = aw_addr_reg[5:2];

  // write address legality, for bresp
  reg wr_legal;
  always @* begin
    case (aw_addr_reg & `CMS_WIN_MASK)
      `CMS_OFS_TXWIN: wr_legal = 1'b1;
      `CMS_OFS_RXWIN: wr_legal = 1'b1;
      default: wr_legal = aw_addr_reg <= `CMS_OFS_RXFLG && aw_addr_reg[1:0] == 2'h0;
    endcase
  end

  // --- transmit scheduling ---
  wire tx_done = pe_tx_done_in & active_reg;
  reg [2:0] done_hot;
  reg [2:0] abort_grant;
  always @* begin
    done_hot = 3'h0;
    if (tx_done) done_hot[active_idx_reg] = 1'b1;
    // a buffer on the bus cannot be aborted
    abort_grant = abort_request_bit_reg & ~txe_reg & ~({3{active_reg}} & (3'h1 << active_idx_reg));
  end
  wire [2:0] txe_set = done_hot | abort_grant;
  // aborted buffers drop out of arbitration in the same cycle
  wire [2:0] ready = ~txe_reg & ~abort_grant & ~abort_request_bit_reg;
  wire [2:0] pick = pick_buffer(ready, tx_mem_reg[tx_index(2'h0, `CMS_TX_LOCAL_PRIORITY_FIELD_IDX)],
    tx_mem_reg[tx_index(2'h1, `CMS_TX_LOCAL_PRIORITY_FIELD_IDX)], tx_mem_reg[tx_index(2'h2, `CMS_TX_LOCAL_PRIORITY_FIELD_IDX)]);
  wire arb_go = pe_arb_in & ~init_mode & ~active_reg & pick[2];
  // next bus-busy state, so the acknowledge gate follows a lost arbitration at once
  wire active_next = arb_go | (active_reg & ~(pe_tx_done_in | pe_tx_fail_in | init_mode));

  // --- receive commit ---
  // own frames only count while loopback is on; lost arbitration ends active
  wire rx_take = pe_rx_ok_in & pe_rx_accept_in & (~active_reg | loop_en);
  wire rx_full = (count_reg == `CMS_FIFO_DEPTH);
  wire rx_commit = rx_take & ~rx_full;
  wire rx_overrun = rx_take & rx_full;
  wire rx_release = wr_rxflg & w_byte_reg[`CMS_RXF_FULL_BIT] & (count_reg != 3'h0);

  // stamp timer
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      timer_reg <= 16'h0000;
    end else if (ce_in) begin
      if (init_mode) begin
        timer_reg <= 16'h0000;
      end else if (pe_bit_tick_in) begin
        timer_reg <= timer_reg + 16'h0001;
      end
    end
  end

  // control, flags, arbitration and events
  integer i;
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `CMS_CTRL_RESET;
      txe_reg <= `CMS_TXE_RESET;
      abort_request_bit_reg <= 3'h0;
      abort_acknowledge_flag_reg <= 3'h0;
      sel_reg <= `CMS_TXSEL_RESET;
      ovr_reg <= 1'b0;
      active_reg <= 1'b0;
      active_idx_reg <= 2'h0;
      pick_valid_reg <= 1'b0;
      ack_en_reg <= 1'b1;
      tx_ev_reg <= 1'b0;
      rx_ev_reg <= 1'b0;
      ovr_ev_reg <= 1'b0;
    end else if (ce_in) begin
      if (wr_en && aw_addr_reg == `CMS_OFS_CTRL) begin
        ctrl_reg <= w_byte_reg[2:0];
      end
      // select maps the lowest requested empty buffer into the window
      if (wr_en && aw_addr_reg == `CMS_OFS_TXSEL) begin
        sel_reg <= lowest_bit(w_byte_reg[2:0] & txe_reg);
      end
      for (i = 0; i < 3; i = i + 1) begin
        // hardware set beats a host clear in the same cycle
        if (txe_set[i]) begin
          txe_reg[i] <= 1'b1;
        end else if (wr_txflg && w_byte_reg[i]) begin
          txe_reg[i] <= 1'b0;
        end
        if (abort_grant[i]) begin
          abort_acknowledge_flag_reg[i] <= 1'b1;
        end else if (done_hot[i]) begin
          abort_acknowledge_flag_reg[i] <= 1'b0;
        end else if (wr_txflg && w_byte_reg[i]) begin
          abort_acknowledge_flag_reg[i] <= 1'b0;
        end
        // requests on empty buffers are ignored
        if (txe_set[i]) begin
          abort_request_bit_reg[i] <= 1'b0;
        end else if (wr_abort_request_bit && w_byte_reg[i] && !txe_reg[i]) begin
          abort_request_bit_reg[i] <= 1'b1;
        end
      end
      // transmission bookkeeping; error or lost arbitration frees the slot
      pick_valid_reg <= arb_go;
      if (arb_go) begin
        active_reg <= 1'b1;
        active_idx_reg <= pick[1:0];
      end else if (pe_tx_done_in || pe_tx_fail_in || init_mode) begin
        active_reg <= 1'b0;
      end
      // no acknowledge for own frames unless looped back
      ack_en_reg <= ~active_next | loop_en;
      if (rx_overrun) begin
        ovr_reg <= 1'b1;
      end else if (wr_rxflg && w_byte_reg[`CMS_RXF_OVR_BIT]) begin
        ovr_reg <= 1'b0;
      end
      tx_ev_reg <= |txe_set;
      rx_ev_reg <= rx_commit;
      ovr_ev_reg <= rx_overrun;
    end
  end

  // transmit buffer storage; snapshot of the picked message for the engine
  integer j;
  always @(posedge clk_in) begin
    if (ce_in) begin
      // host writes only reach an empty, selected buffer; stamps are not writable
      if (wr_txwin && sel_empty && wr_win_idx < `CMS_TX_STAMP_HI_IDX) begin
        tx_mem_reg[tx_index(sel_idx, wr_win_idx)] <= w_byte_reg;
      end
      if (tx_done && time_en) begin
        tx_mem_reg[tx_index(active_idx_reg, `CMS_TX_STAMP_HI_IDX)] <= timer_reg[15:8];
        tx_mem_reg[tx_index(active_idx_reg, `CMS_TX_STAMP_LO_IDX)] <= timer_reg[7:0];
      end
      if (arb_go) begin
        for (j = 0; j < 13; j = j + 1) begin
          tx_msg_reg[j*8 +: 8] <= tx_mem_reg[tx_index(pick[1:0], j[3:0])];
        end
      end
    end
  end

  // background buffer, written while filtering runs
  always @(posedge clk_in) begin
    if (ce_in && pe_rx_wr_in && pe_rx_idx_in < `CMS_MSG_BYTES) begin
      bg_mem_reg[pe_rx_idx_in] <= pe_rx_byte_in;
    end
  end

  // fifo storage: a commit copies the background buffer plus stamp
  integer k;
  always @(posedge clk_in) begin
    if (ce_in && rx_commit) begin
      for (k = 0; k < 13; k = k + 1) begin
        rx_mem_reg[rx_index(wr_ptr_reg, k[3:0])] <= bg_mem_reg[k];
      end
      rx_mem_reg[rx_index(wr_ptr_reg, `CMS_RX_STAMP_HI_IDX)] <=
        time_en ? timer_reg[15:8] : 8'h00;
      rx_mem_reg[rx_index(wr_ptr_reg, `CMS_RX_STAMP_LO_IDX)] <=
        time_en ? timer_reg[7:0] : 8'h00;
    end
  end

  // fifo pointers, arrival order kept
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_reg <= 3'h0;
      wr_ptr_reg <= 3'h0;
      count_reg <= 3'h0;
    end else if (ce_in) begin
      if (rx_commit) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (rx_release) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      case ({rx_commit, rx_release})
        2'b10: count_reg <= count_reg + 3'h1;
        2'b01: count_reg <= count_reg - 3'h1;
        default: count_reg <= count_reg;
      endcase
    end
  end

  // read mux; reads have no side effects
  reg [31:0] rd_data;
  reg rd_err;
  always @* begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    case (s_axi_araddr_in & `CMS_WIN_MASK)
      `CMS_OFS_TXWIN: begin
        // window only readable while the selected buffer is empty
        if (sel_empty) begin
          rd_data[7:0] = tx_mem_reg[tx_index(sel_idx, s_axi_araddr_in[5:2])];
        end
      end
      `CMS_OFS_RXWIN: begin
        // only the foreground stage is visible
        if (s_axi_araddr_in[5:2] < `CMS_RX_BYTES) begin
          rd_data[7:0] = rx_mem_reg[rx_index(rd_ptr_reg, s_axi_araddr_in[5:2])];
        end
      end
      default: begin
        case (s_axi_araddr_in)
          `CMS_OFS_CTRL: rd_data[2:0] = ctrl_reg;
          `CMS_OFS_TXFLG: rd_data[2:0] = txe_reg;
          `CMS_OFS_ABORT_REQUEST_BIT: rd_data[2:0] = abort_request_bit_reg;
          `CMS_OFS_ABORT_ACKNOWLEDGE_FLAG: rd_data[2:0] = abort_acknowledge_flag_reg;
          `CMS_OFS_TXSEL: rd_data[2:0] = sel_reg;
          `CMS_OFS_RXFLG: rd_data[1:0] = {ovr_reg, count_reg != 3'h0};
          default: rd_err = 1'b1;
        endcase
      end
    endcase
  end

  // axi write channels: address and data taken in either order
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_byte_reg <= 8'h00;
      w_strb_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `CMS_RESP_OKAY;
    end else if (ce_in) begin
      if (s_axi_awvalid_in && awready_reg) begin
        aw_addr_reg <= s_axi_awaddr_in;
        aw_have_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid_in && wready_reg) begin
        w_byte_reg <= s_axi_wdata_in[7:0];
        w_strb_reg <= s_axi_wstrb_in[0];
        w_have_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_legal ? `CMS_RESP_OKAY : `CMS_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready_in) begin
        // re-arm only after the response, one write in flight
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // axi read channel
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `CMS_RESP_OKAY;
    end else if (ce_in) begin
      if (s_axi_arvalid_in && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_data;
        rresp_reg <= rd_err ? `CMS_RESP_SLVERR : `CMS_RESP_OKAY;
      end else if (rvalid_reg && s_axi_rready_in) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // init mode mirror, registered for the output rule
  reg init_out_reg;
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      init_out_reg <= 1'b1;
    end else if (ce_in) begin
      init_out_reg <= init_mode;
    end
  end

  assign s_axi_awready_out = awready_reg;
  assign s_axi_wready_out = wready_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_arready_out = arready_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rready_unused_out = rvalid_reg;
  assign tx_pick_valid_out = pick_valid_reg;
  assign tx_pick_idx_out = active_idx_reg;
  assign tx_msg_out = tx_msg_reg;
  assign ack_enable_out = ack_en_reg;
  assign init_mode_out = init_out_reg;
  assign tx_event_out = tx_ev_reg;
  assign rx_event_out = rx_ev_reg;
  assign overrun_event_out = ovr_ev_reg;

endmodule // cms_top

// >>> bench/cms_checker.sv
// port-level assertions for the message storage top
// assumes it is bound to cms_top and sees only its ports
module cms_checker (
  input wire clk_in,
  input wire resetn_in,
  input wire s_axi_awvalid_in,
  input wire s_axi_awready_out,
  input wire s_axi_wvalid_in,
  input wire s_axi_wready_out,
  input wire s_axi_bvalid_out,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire s_axi_rvalid_out,
  input wire pe_arb_in,
  input wire pe_tx_done_in,
  input wire pe_tx_fail_in,
  input wire pe_rx_ok_in,
  input wire pe_rx_accept_in,
  input wire tx_pick_valid_out,
  input wire ack_enable_out,
  input wire init_mode_out,
  input wire tx_event_out,
  input wire rx_event_out,
  input wire overrun_event_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic act_reg; // a picked buffer is on the bus
  // shadow of the active slot, freed by done, fail or init
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      act_reg <= 1'b0;
    end else if (pe_tx_done_in || pe_tx_fail_in || init_mode_out) begin
      act_reg <= 1'b0;
    end else if (tx_pick_valid_out) begin
      act_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  pick_cause_a: assert property (
    tx_pick_valid_out |-> $past(pe_arb_in)) else $error("pick without arbitration");
  pick_pulse_a: assert property (
    tx_pick_valid_out |=> !tx_pick_valid_out) else $error("pick longer than a cycle");
  sent_event_a: assert property (
    pe_tx_done_in && act_reg |=> tx_event_out) else $error("no transmit event");
  rx_cause_a: assert property (
    rx_event_out || overrun_event_out |-> $past(pe_rx_ok_in && pe_rx_accept_in))
    else $error("receive event without accepted frame");
  rx_reject_a: assert property (
    pe_rx_ok_in && !pe_rx_accept_in |=> !rx_event_out && !overrun_event_out)
    else $error("rejected frame stored");
  own_frame_a: assert property (
    pe_rx_ok_in && !ack_enable_out |=> !rx_event_out) else $error("own frame stored");
  ovr_excl_a: assert property (
    overrun_event_out |-> !rx_event_out) else $error("overrun and store together");
  wr_answer_a: assert property (
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |-> ##[1:2] s_axi_bvalid_out) else $error("write response missing");
  rd_answer_a: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out) else $error("read data late");
endmodule // cms_checker

bind cms_top cms_checker i_cms_checker (.*);

// >>> bench/cms_pe_model.sv
// protocol engine and bus stand-in: bit ticks, arbitration, frames
// assumes the bench calls its tasks one at a time
module cms_pe_model (
  input wire clk_in,
  output logic tick_out,
  output logic arb_out,
  output logic done_out,
  output logic fail_out,
  output logic wr_out,
  output logic [3:0] idx_out,
  output logic [7:0] byte_out,
  output logic ok_out,
  output logic acc_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet: strobes low, data parked on a pattern
  initial begin
    {tick_out, arb_out, done_out, fail_out, wr_out, ok_out, acc_out} = 7'h0;
    idx_out = 4'h0;
    byte_out = 8'ha5;
  end
  // one-cycle strobe: 0 arbitrate, 1 sent, 2 failed, else one bit time
  task automatic pulse(input int k);
    @(posedge clk_in);
    case (k)
      0: arb_out <= 1'b1;
      1: done_out <= 1'b1;
      2: fail_out <= 1'b1;
      default: tick_out <= 1'b1;
    endcase
    @(posedge clk_in);
    {arb_out, done_out, fail_out, tick_out} <= 4'h0;
  endtask
  // 13 bytes b, b+1.., then the end-of-frame verdict
  task automatic frame(input logic [7:0] b, input logic acc);
    for (int i = 0; i < 13; i++) begin
      @(posedge clk_in);
      wr_out <= 1'b1;
      idx_out <= 4'(i);
      byte_out <= b + 8'(i);
    end
    @(posedge clk_in);
    wr_out <= 1'b0;
    byte_out <= ~byte_out; // released data must not look valid
    ok_out <= 1'b1;
    acc_out <= acc;
    @(posedge clk_in);
    ok_out <= 1'b0;
    acc_out <= ~acc;
  endtask
endmodule // cms_pe_model

// >>> bench/test_can_message_storage.sv
// self-checking bench for cms_top: axi master tasks and scenarios
// assumes cms_pe_model drives the engine side
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_can_message_storage;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0, d;
  logic [31:0] wdata = 32'h0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0, ce = 1'b1;
  logic [3:0] strb = 4'h1;
  logic [1:0] r;
  logic [103:0] me;
  wire tick, arb, done, fail, pwr, ok, acc, bv, rv, pick, tev, rev, oev;
  wire awr, wr_rdy, arr, ack, initm;
  wire [3:0] pidx;
  wire [7:0] pbyte;
  wire [1:0] bresp, rresp, idx;
  wire [31:0] rdata;
  wire [103:0] msg;
  int n_errors = 0, check_count = 0, ntx = 0, nrx = 0, novr = 0, npick = 0;
  always #4 clk_in = ~clk_in;
  // tallies of the one-cycle event pulses
  always @(posedge clk_in) begin
    ntx += tev;
    nrx += rev;
    novr += oev;
    npick += pick;
  end
  cms_pe_model i_cms_pe_model (.clk_in(clk_in), .tick_out(tick), .arb_out(arb),
    .done_out(done), .fail_out(fail), .wr_out(pwr), .idx_out(pidx), .byte_out(pbyte),
    .ok_out(ok), .acc_out(acc));
  cms_top i_cms_top (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr_rdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_unused_out(), .s_axi_rready_in(rready),
    .pe_bit_tick_in(tick), .pe_arb_in(arb), .pe_tx_done_in(done), .pe_tx_fail_in(fail),
    .pe_rx_wr_in(pwr), .pe_rx_idx_in(pidx), .pe_rx_byte_in(pbyte), .pe_rx_ok_in(ok),
    .pe_rx_accept_in(acc), .tx_pick_valid_out(pick), .tx_pick_idx_out(idx),
    .tx_msg_out(msg), .ack_enable_out(ack), .init_mode_out(initm), .tx_event_out(tev),
    .rx_event_out(rev), .overrun_event_out(oev));
  task automatic tally_and_finish;
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // a wait that ran out ends the run
  task automatic hang(input int n);
    if (n >= 40) begin
      n_errors++;
      $display("[FAIL] bus answer expected 1 seen 0");
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    int n = 0;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= {24'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (!bv && n < 40);
    r = bresp;
    bready <= 1'b0;
    hang(n);
  endtask
  task automatic rd(input logic [7:0] a);
    int n = 0;
    @(posedge clk_in);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (arr) arv <= 1'b0;
    end while (!rv && n < 40);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
    hang(n);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK(nm, e, d)
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_in);
  endtask
  task automatic t_reset;
    strb <= 4'h0;
    wr(8'h00, 8'h06);
    strb <= 4'h1;
    rc("ctrl", 8'h00, 8'h01);
    rc("tx empty", 8'h04, 8'h07);
    rc("abort ack", 8'h0c, 8'h00);
    rc("rx flags", 8'h14, 8'h00);
    rd(8'h20);
    `CHK("unmapped", 2'h2, r)
    wr(8'h20, 8'h00);
    `CHK("wr unmapped", 2'h2, r)
  endtask
  // fill all three buffers through the shared window
  task automatic t_fill;
    wr(8'h00, 8'h02);
    for (int i = 0; i < 3; i++) i_cms_pe_model.pulse(3);
    for (int b = 0; b < 3; b++) begin
      wr(8'h10, 8'(1 << b));
      rc("select", 8'h10, 8'(1 << b));
      for (int n = 0; n < 14; n++) wr(8'h40 + 8'(4 * n), n == 13 ? (b == 0 ? 8'h5 : 8'h3) : 8'(16 * b + n));
      rc("window", 8'h54, 8'(16 * b + 5));
    end
    wr(8'h04, 8'h07);
    rc("busy window", 8'h40, 8'h00);
  endtask
  task automatic t_local_priority_field;
    i_cms_pe_model.pulse(0);
    settle();
    `CHK("pick", 2'h1, idx)
    for (int j = 0; j < 13; j++) me[8 * j +: 8] = 8'h10 + 8'(j);
    `CHK("message", me, msg)
    i_cms_pe_model.pulse(1);
    settle();
    `CHK("tx events", 1, ntx)
    rc("empty after send", 8'h04, 8'h02);
    rc("ack after send", 8'h0c, 8'h00);
    wr(8'h10, 8'h02);
    wr(8'h7c, 8'h55);
    rc("stamp high", 8'h78, 8'h00);
    rc("stamp low", 8'h7c, 8'h03);
    ce <= 1'b0;
    i_cms_pe_model.pulse(3);
    ce <= 1'b1;
    i_cms_pe_model.pulse(3);
    i_cms_pe_model.pulse(0);
    i_cms_pe_model.pulse(2);
    i_cms_pe_model.pulse(0);
    settle();
    `CHK("re-pick", 3, npick)
    `CHK("re-pick idx", 2'h2, idx)
    wr(8'h08, 8'h04);
    i_cms_pe_model.pulse(1);
    settle();
    rc("ack sent", 8'h0c, 8'h00);
    rc("empty", 8'h04, 8'h06);
    wr(8'h10, 8'h04);
    rc("stamp 2", 8'h7c, 8'h04);
  endtask
  task automatic t_abort;
    wr(8'h08, 8'h01);
    settle();
    rc("abort ack", 8'h0c, 8'h01);
    rc("released", 8'h04, 8'h07);
    `CHK("abort event", 3, ntx)
  endtask
  task automatic t_own;
    wr(8'h04, 8'h01);
    i_cms_pe_model.pulse(0);
    i_cms_pe_model.frame(8'h40, 1'b1);
    settle();
    `CHK("own frame", 0, nrx)
    `CHK("no ack", 1'b0, ack)
    i_cms_pe_model.pulse(1);
    settle();
    rc("sent ack", 8'h0c, 8'h00);
  endtask
  task automatic t_loop;
    wr(8'h00, 8'h06);
    wr(8'h04, 8'h01);
    i_cms_pe_model.pulse(0);
    i_cms_pe_model.frame(8'h50, 1'b1);
    i_cms_pe_model.pulse(1);
    settle();
    `CHK("loop frame", 1, nrx)
    rc("loop byte", 8'h80, 8'h50);
    wr(8'h14, 8'h01);
    rc("released", 8'h14, 8'h00);
    wr(8'h00, 8'h02);
  endtask
  // timer cleared by init, fifo filled past full, drained in order
  task automatic t_fifo;
    wr(8'h00, 8'h03);
    i_cms_pe_model.pulse(3);
    `CHK("init pin", 1'b1, initm)
    wr(8'h00, 8'h02);
    i_cms_pe_model.pulse(3);
    i_cms_pe_model.pulse(3);
    i_cms_pe_model.frame(8'h60, 1'b0);
    for (int k = 0; k < 6; k++) i_cms_pe_model.frame(8'h70 + 8'(16 * k), 1'b1);
    settle();
    `CHK("stored", 6, nrx)
    `CHK("overrun", 1, novr)
    rc("rx flags", 8'h14, 8'h03);
    wr(8'h04, 8'h01);
    i_cms_pe_model.pulse(0);
    i_cms_pe_model.pulse(1);
    settle();
    `CHK("send while full", 6, ntx)
    for (int k = 0; k < 5; k++) begin
      rc("oldest", 8'h80, 8'h70 + 8'(16 * k));
      rc("last byte", 8'hb0, 8'h7c + 8'(16 * k));
      rc("rx stamp", 8'hb8, 8'h02);
      wr(8'h14, 8'h01);
    end
    rc("drained", 8'h14, 8'h02);
    wr(8'h14, 8'h02);
    i_cms_pe_model.frame(8'h90, 1'b1);
    settle();
    rc("accepting again", 8'h14, 8'h01);
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_reset();
    t_fill();
    t_local_priority_field();
    t_abort();
    t_own();
    t_loop();
    t_fifo();
    tally_and_finish();
  end
endmodule // test_can_message_storage
